/* File: hdl/arc_defs.svh */
// constants of the conversion-control and parallel result port
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH

`define ARC_CLK_NS        100
`define ARC_HOLD_NS       40
// least hold time rounded up to whole clocks, never below one
`define ARC_HOLD_CYC_RAW  ((`ARC_HOLD_NS + `ARC_CLK_NS - 1) / `ARC_CLK_NS)
`define ARC_HOLD_CYC      ((`ARC_HOLD_CYC_RAW < 1) ? 1 : `ARC_HOLD_CYC_RAW)
`define ARC_HOLD_W        4
`define ARC_WORD_W        16
`define ARC_BYTE_W        8
`define ARC_BUF_DEPTH     2
`define ARC_WORD_RST      16'h0000
// synchroniser reset: half select low, read/convert and select idle high
`define ARC_PIN_IDLE      3'h3

`endif

/* File: hdl/arc_pkg.sv */
// types shared by the result port and its buffer
package arc_pkg;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} arc_word_t;

	typedef enum logic [1:0] {
		ARC_IDLE,
		ARC_START,
		ARC_CONV
	} arc_state_t;

endpackage

/* File: hdl/arc_buf.sv */
// two-entry buffer between the converter core and the result register
`include "arc_defs.svh"

module arc_buf (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// filling side
	input  wire logic               in_valid_i,
	output logic                    in_ready_o,
	input  wire arc_pkg::arc_word_t in_data_i,
	// draining side
	output logic                    out_valid_o,
	input  wire logic               out_ready_i,
	output arc_pkg::arc_word_t      out_data_o
);

	arc_pkg::arc_word_t mem_r [`ARC_BUF_DEPTH];
	arc_pkg::arc_word_t mem_nxt [`ARC_BUF_DEPTH];
	logic               wr_ptr_r,  wr_ptr_nxt;
	logic               rd_ptr_r,  rd_ptr_nxt;
	logic [1:0]         count_r,   count_nxt;
	logic               push;
	logic               pop;

	////////////////////////////////////////////////////////////////////////////////
	assign in_ready_o  = (count_r != 2'h2);
	assign out_valid_o = (count_r != 2'h0);
	assign out_data_o  = mem_r[rd_ptr_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		mem_nxt    = mem_r;
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt  = count_r;
		if (push) begin
			mem_nxt[wr_ptr_r] = in_data_i;
			wr_ptr_nxt        = ~wr_ptr_r;
		end
		if (pop) begin
			rd_ptr_nxt = ~rd_ptr_r;
		end
		if (push && !pop) begin
			count_nxt = count_r + 2'h1;
		end else if (pop && !push) begin
			count_nxt = count_r - 2'h1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `ARC_BUF_DEPTH; i++) begin
				mem_r[i] <= `ARC_WORD_RST;
			end
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r  <= 2'h0;
		end else begin
			mem_r    <= mem_nxt;
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= count_nxt;
		end
	end

endmodule // arc_buf

/* File: hdl/arc_port.sv */
// conversion control and three-state parallel result port
//
// Function
// RULE1: every result appears as one 16-bit word on the parallel outputs.
// RULE2: results are passed on as two's complement values, untouched.
// RULE3: busy output low from conversion start until the new result is loaded.
// RULE4: half-word select low gives upper eight bits, high gives lower eight.
// RULE5: select and read/convert are ORed; both low starts a conversion.
// RULE6: outputs are off while select is high or read/convert is low.
// RULE7: top output bit carries the result's most significant bit; with half select high the code puts result bit 7 there.
// RULE8: host holds both lines low at least 40 ns to start a conversion.
// RULE9: with select low, outputs enable when read/convert goes high.
// RULE10: host leaves about 4 us between convert commands.
`include "arc_defs.svh"

module arc_port (
	// clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// host pins
	input  wire logic                    cs_n_i,
	input  wire logic                    rc_i,
	input  wire logic                    byte_i,
	output logic                         busy_n_o,
	output logic [`ARC_WORD_W-1:0]       data_o,
	output logic [`ARC_WORD_W-1:0]       data_oe_o,
	// converter core
	output logic                         conv_start_o,
	input  wire logic                    res_valid_i,
	output logic                         res_ready_o,
	input  wire logic [`ARC_WORD_W-1:0]  res_data_i
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage one is read only by stage two
	logic [2:0] pin_meta_r;
	logic [2:0] pin_sync_r;
	logic       cs_n_s;
	logic       rc_s;
	logic       byte_s;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta_r <= `ARC_PIN_IDLE;
			pin_sync_r <= `ARC_PIN_IDLE;
		end else begin
			pin_meta_r <= {byte_i, rc_i, cs_n_i};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign cs_n_s = pin_sync_r[0];
	assign rc_s   = pin_sync_r[1];
	assign byte_s = pin_sync_r[2];

	////////////////////////////////////////////////////////////////////////////////
	// buffer between core and result register
	arc_pkg::arc_word_t core_word;
	arc_pkg::arc_word_t buf_word;
	logic               buf_valid;
	logic               buf_ready;

	assign core_word = res_data_i; // see RULE2

	arc_buf u_buf (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (res_valid_i),
		.in_ready_o  (res_ready_o),
		.in_data_i   (core_word),
		.out_valid_o (buf_valid),
		.out_ready_i (buf_ready),
		.out_data_o  (buf_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// conversion control
	arc_pkg::arc_state_t      state_r,  state_nxt;
	logic [`ARC_HOLD_W-1:0]   hold_r,   hold_nxt;
	logic                     armed_r,  armed_nxt;
	arc_pkg::arc_word_t       result_r, result_nxt;
	logic                     conv_low;
	logic                     start_evt;

	assign conv_low  = cs_n_s | rc_s ? 1'b0 : 1'b1; // see RULE5
	// hold length counted in whole clocks; at one clock a low whose first synchronised cycle falls in the idle state starts a conversion
	assign start_evt = conv_low && armed_r
		&& (hold_r == `ARC_HOLD_W'(`ARC_HOLD_CYC - 1)); // see RULE8

	// the buffer drains only into a waiting conversion; a stale word waits
	assign buf_ready = (state_r == arc_pkg::ARC_CONV);

	always_comb begin
		state_nxt  = state_r;
		hold_nxt   = hold_r;
		armed_nxt  = armed_r;
		result_nxt = result_r;
		if (!conv_low) begin
			hold_nxt  = '0;
			armed_nxt = 1'b1;
		end else if (hold_r != {`ARC_HOLD_W{1'b1}}) begin
			hold_nxt = hold_r + `ARC_HOLD_W'(1);
		end
		unique case (state_r)
			arc_pkg::ARC_IDLE: begin
				if (start_evt) begin
					state_nxt = arc_pkg::ARC_START; // see RULE5
					armed_nxt = 1'b0;
				end
			end
			arc_pkg::ARC_START: begin
				state_nxt = arc_pkg::ARC_CONV;
			end
			arc_pkg::ARC_CONV: begin
				if (buf_valid) begin
					result_nxt = buf_word; // see RULE1
					state_nxt  = arc_pkg::ARC_IDLE; // see RULE3
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r  <= arc_pkg::ARC_IDLE;
			hold_r   <= '0;
			armed_r  <= 1'b0;
			result_r <= `ARC_WORD_RST;
		end else begin
			state_r  <= state_nxt;
			hold_r   <= hold_nxt;
			armed_r  <= armed_nxt;
			result_r <= result_nxt;
		end
	end

	assign conv_start_o = (state_r == arc_pkg::ARC_START);
	// the pins take the new word at the edge busy rises, so that edge can latch it
	assign busy_n_o     = (state_r == arc_pkg::ARC_IDLE); // see RULE3

	////////////////////////////////////////////////////////////////////////////////
	// output pins, registered
	logic [`ARC_WORD_W-1:0] pins_r,  pins_nxt;
	logic [`ARC_WORD_W-1:0] oe_r,    oe_nxt;
	logic                   drive;

	assign drive = !cs_n_s && rc_s; // see RULE6 see RULE9

	always_comb begin
		// top pin carries the msb of whichever half is chosen; fed from the next
		// result so the pins never lag the busy release by a cycle
		if (byte_s) begin
			pins_nxt = {result_nxt.lo, result_nxt.hi}; // see RULE4 see RULE7
		end else begin
			pins_nxt = {result_nxt.hi, result_nxt.lo}; // see RULE4 see RULE7
		end
		oe_nxt = {`ARC_WORD_W{drive}}; // see RULE6
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pins_r <= `ARC_WORD_RST;
			oe_r   <= `ARC_WORD_RST;
		end else begin
			pins_r <= pins_nxt;
			oe_r   <= oe_nxt;
		end
	end

	assign data_o    = pins_r;
	assign data_oe_o = oe_r;

endmodule // arc_port

/* File: tb/arc_core_model.sv */
// converter core stand-in: answers each start with the word it is given
module arc_core_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// control from the bench and the port
	input  wire logic        conv_start_i,
	input  wire logic [7:0]  delay_i,
	input  wire logic [15:0] word_i,
	// result handshake
	input  wire logic        res_ready_i,
	output logic             res_valid_o,
	output logic [15:0]      res_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_r;
	logic       wait_r;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= 8'h00;
			wait_r <= 1'b0;
			res_valid_o <= 1'b0;
			res_data_o <= 16'h0000;
		end else if (conv_start_i) begin
			cnt_r <= delay_i;
			wait_r <= 1'b1;
		end else if (wait_r && cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end else if (wait_r) begin
			res_valid_o <= 1'b1;
			res_data_o <= word_i;
			wait_r <= 1'b0;
		end else if (res_valid_o && res_ready_i) begin
			res_valid_o <= 1'b0;
			// released data shows the inverse so a stale word cannot pass
			res_data_o <= ~res_data_o;
		end
	end
endmodule // arc_core_model

/* File: tb/arc_port_asserts.sv */
// concurrent checks on the result port pins
`include "arc_defs.svh"
module arc_port_asserts (
	// all ports of the result port
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  cs_n_i,
	input wire logic                  rc_i,
	input wire logic                  byte_i,
	input wire logic                  busy_n_o,
	input wire logic [`ARC_WORD_W-1:0] data_o,
	input wire logic [`ARC_WORD_W-1:0] data_oe_o,
	input wire logic                  conv_start_o,
	input wire logic                  res_valid_i,
	input wire logic                  res_ready_o,
	input wire logic [`ARC_WORD_W-1:0] res_data_i
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take; res_valid_i && res_ready_o; endsequence
	property p_start; conv_start_o |-> !busy_n_o; endproperty
	a_start: assert property (p_start) else $error("start without busy");
	property p_pulse; conv_start_o |=> !conv_start_o && !busy_n_o; endproperty
	a_pulse: assert property (p_pulse) else $error("start pulse wrong");
	property p_fall; $fell(busy_n_o) |-> conv_start_o; endproperty
	a_fall: assert property (p_fall) else $error("busy fell alone");
	property p_load; s_take ##0 !busy_n_o |-> ##[1:4] busy_n_o; endproperty
	a_load: assert property (p_load) else $error("result not loaded");
	property p_cause; conv_start_o |-> $past(cs_n_i || rc_i, 3) == 1'b0; endproperty
	a_cause: assert property (p_cause) else $error("start without request");
	property p_off; (cs_n_i || !rc_i) |-> ##3 data_oe_o == '0; endproperty
	a_off: assert property (p_off) else $error("outputs driven");
	property p_on; (!cs_n_i && rc_i) |-> ##3 data_oe_o == '1; endproperty
	a_on: assert property (p_on) else $error("outputs not driven");
	property p_swap; $past(byte_i, 3) != $past(byte_i, 4) && $past(busy_n_o, 2)
		|-> data_o == {$past(data_o[7:0]), $past(data_o[15:8])}; endproperty
	a_swap: assert property (p_swap) else $error("halves not swapped");
endmodule // arc_port_asserts
bind arc_port arc_port_asserts u_arc_port_asserts (.clk_i, .rst_i, .cs_n_i, .rc_i, .byte_i,
	.busy_n_o, .data_o, .data_oe_o, .conv_start_o, .res_valid_i, .res_ready_o, .res_data_i);

/* File: tb/tb_arc_port.sv */
// self-checking bench for the result port
`include "arc_defs.svh"
module tb_arc_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, rst_i, cs_n_i, rc_i, byte_i, busy_n_o, conv_start_o;
	logic        res_valid_i, res_ready_o;
	logic [15:0] data_o, data_oe_o, res_data_i, word_r;
	logic [7:0]  delay_r;
	logic [31:0] seed;
	int          fails, samples_checked;
	arc_port u_arc_port (.clk_i, .rst_i, .cs_n_i, .rc_i, .byte_i, .busy_n_o, .data_o,
		.data_oe_o, .conv_start_o, .res_valid_i, .res_ready_o, .res_data_i);
	arc_core_model u_arc_core_model (.clk_i, .rst_i, .conv_start_i(conv_start_o),
		.delay_i(delay_r), .word_i(word_r), .res_ready_i(res_ready_o),
		.res_valid_o(res_valid_i), .res_data_o(res_data_i));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	function automatic logic [15:0] pins(input logic [15:0] w, input logic b);
		return b ? {w[7:0], w[15:8]} : w;
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// via_cs: read/convert goes low first, select's falling edge starts
	task automatic convert(input logic [15:0] w, input logic via_cs);
		int k;
		@(posedge clk_i);
		word_r <= w;
		rc_i <= 1'b0;
		if (via_cs) tick(1);
		cs_n_i <= 1'b0;
		// both low for five cycles, well past the least hold time
		tick(4);
		@(negedge clk_i);
		check("busy low", {15'h0000, busy_n_o}, 16'h0000);
		check("oe in convert", data_oe_o, 16'h0000);
		@(posedge clk_i);
		rc_i <= 1'b1;
		for (k = 0; k < 300 && !busy_n_o; k++) @(negedge clk_i);
		check("busy high", {15'h0000, busy_n_o}, 16'h0001);
		check("word at busy", data_o, pins(w, byte_i));
		tick(4);
		@(negedge clk_i);
		check("oe read", data_oe_o, 16'hffff);
		check("word", data_o, pins(w, byte_i));
		@(posedge clk_i);
		byte_i <= ~byte_i;
		tick(4);
		@(negedge clk_i);
		check("half", data_o, pins(w, byte_i));
		@(posedge clk_i);
		cs_n_i <= 1'b1;
		tick(4);
		@(negedge clk_i);
		check("oe deselect", data_oe_o, 16'h0000);
		// spacing between converts leaves time for acquisition
		tick(40);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		#3000000;
		fails++;
		wrap_up();
	end
	initial begin
		logic [15:0] corner [4];
		corner = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001};
		rst_i = 1'b1;
		cs_n_i = 1'b1;
		rc_i = 1'b1;
		byte_i = 1'b0;
		word_r = 16'h0000;
		delay_r = 8'h00;
		seed = 32'hc1fb9f7a;
		tick(15);
		@(negedge clk_i);
		check("reset flags", {13'h0000, busy_n_o, res_ready_o, conv_start_o}, 16'h0006);
		check("reset oe", data_oe_o, 16'h0000);
		tick(1);
		rst_i <= 1'b0;
		tick(2);
		for (int i = 0; i < 20; i++) begin
			seed = xs(seed);
			delay_r <= {3'h0, seed[20:16]};
			byte_i <= seed[21];
			convert(i < 4 ? corner[i] : seed[15:0], seed[22]);
		end
		wrap_up();
	end
endmodule // tb_arc_port
